//--- verilog/ocp_top.sv
// Overcurrent protection setup: limit and setup registers, accurate
// secondary limit, fast primary trip with cycle-by-cycle PWM cut.
// Assumes a PWM generator, comparator and ADC on or near aclk.
// Contract
// [R01] Set accurate flag when reading exceeds limit
// [R02] Software keeps limit at 254 or below
// [R03] Fast trip needs debounce time above limit
// [R04] Trip cuts all PWM outputs this cycle
// [R05] PWM outputs resume at next cycle start
// [R06] Balance adds modulation to second, fourth drives
// [R07] Bypass takes fast input from flag pin
// [R08] Constant current ten percent below limit
// [R09] Blanking hides leading spike from balance
// [R10] Fast flag after consecutive tripped cycles
// [R11] Timeout codes give 1, 2, 4, 8
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ocp_top #(
  parameter int PWM_N = 6
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ocp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ocp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Pins from outside the clock domain
  input wire logic primary_current_sense_over,
  input wire logic external_flag_input,
  // Same-clock inputs
  input wire logic [7:0] secondary_current_sense,
  input wire logic cycle_start,
  input wire logic [PWM_N-1:0] pwm_in,
  input wire logic bridge_drive_second_mod,
  input wire logic bridge_drive_fourth_mod,
  // Outputs
  output logic [PWM_N-1:0] pwm_out,
  output logic pwm_cut,
  output logic accurate_flag,
  output logic fast_flag,
  output logic cc_mode_active,
  output logic volt_second_balance_on,
  output logic vs_sample_blank
);
  import ocp_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (PWM_N < 4 || PWM_N > 24) begin : g_bad_pwm_n
    $error("PWM_N must lie between 4 and 24");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sense_sync;      // Sense pin synchroniser
    logic [1:0] flag_sync;       // Flag pin synchroniser
    logic [7:0] limit;           // Accurate limit register
    logic [7:0] setup;           // Fast setup register
    logic acc_flag;              // Sticky accurate flag
    logic fast_flag;             // Sticky fast flag
    logic cc_act;                // Constant-current active
    logic cut;                   // PWM cut for rest of cycle
    logic [PWM_N-1:0] pwm;       // Gated PWM outputs
    logic [3:0] blank_cnt;       // Blanking window counter
    logic blank;                 // Blanking active
    logic aw_have;               // Write address held
    logic [ADDR_W-1:0] aw_addr;  // Held write address
    logic w_have;                // Write data held
    logic [31:0] w_data;         // Held write data
    logic w_lane0;               // Low byte lane enabled
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ocp_top_s;

  ocp_top_s st_reg;
  ocp_top_s st_next;
  logic fast_level;    // Selected fast source
  logic fast_trip;     // Debounced trip
  logic fast_reached;  // Consecutive count reached
  logic [7:0] cc_level;
  logic acc_over;
  logic [PWM_N-1:0] pwm_mod;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  // Word-aligned match against one register
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    addr_hit = (a[ADDR_W-1:2] == r[ADDR_W-1:2]);
  endfunction

  // ----------------------------------------------------------------
  // Fast path submodules
  // ----------------------------------------------------------------
  // [R07] Source select bypass
  assign fast_level = st_reg.setup[SET_BYPASS] ? st_reg.flag_sync[1] : st_reg.sense_sync[1];

  // [R03] Debounce before trip
  ocp_debounce u_debounce (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(fast_level),
    .code(st_reg.setup[SET_DEB_HI:SET_DEB_LO]),
    .trip(fast_trip)
  );

  // [R11] Timeout code counts
  ocp_cycle_count u_cycle_count (
    .aclk(aclk),
    .aresetn(aresetn),
    .cycle_start(cycle_start),
    .trip(fast_trip),
    .code(st_reg.setup[SET_TMO_HI:SET_TMO_LO]),
    .reached(fast_reached)
  );

  // ----------------------------------------------------------------
  // Secondary limit compare
  // ----------------------------------------------------------------
  // [R08] Level one tenth below
  assign cc_level = st_reg.limit - 8'(st_reg.limit / 8'(CC_MARGIN_DIV));
  // [R01] Strictly greater compare
  assign acc_over = secondary_current_sense > st_reg.limit;

  // Status word as read by software
  always_comb begin
    status_word = 32'h0;
    status_word[ST_ACC_FLAG] = st_reg.acc_flag;
    status_word[ST_FAST_FLAG] = st_reg.fast_flag;
    status_word[ST_CC_ACT] = st_reg.cc_act;
    status_word[ST_CUT_ACT] = st_reg.cut;
    status_word[ST_READ_LO +: 8] = secondary_current_sense;
  end

  // [R06] Extra modulation on bridge drives
  always_comb begin
    pwm_mod = pwm_in;
    if (st_reg.setup[SET_VSB_ON]) begin
      pwm_mod[1] = pwm_in[1] | bridge_drive_second_mod;
      pwm_mod[3] = pwm_in[3] | bridge_drive_fourth_mod;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // Two-stage synchronisers for the pins
    st_next.sense_sync = {st_reg.sense_sync[0], primary_current_sense_over};
    st_next.flag_sync = {st_reg.flag_sync[0], external_flag_input};

    // [R04] Cut on trip for the cycle
    // [R05] Resume at next cycle start
    if (fast_trip) begin
      st_next.cut = 1'b1;
    end else if (cycle_start) begin
      st_next.cut = 1'b0;
    end
    // Trip blocks outputs in the same edge it is seen
    for (int i = 0; i < PWM_N; i++) begin
      st_next.pwm[i] = pwm_mod[i] && !st_next.cut;
    end

    // [R08] Constant-current mode gate
    st_next.cc_act = st_reg.setup[SET_CC_ON] && (secondary_current_sense >= cc_level);

    // [R09] Leading-edge blanking window
    if (cycle_start) begin
      st_next.blank_cnt = 4'(BLANK_CYC);
    end else if (st_reg.blank_cnt != 4'h0) begin
      st_next.blank_cnt = st_reg.blank_cnt - 4'h1;
    end
    st_next.blank = st_reg.setup[SET_BLANK] && (st_next.blank_cnt != 4'h0);

    // Write address and data channels, in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_lane0 = s_axi_wstrb[0];
    end
    // Write response drained
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Sticky flags: set below wins over a clear here
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      if (addr_hit(st_reg.aw_addr, ADDR_LIMIT)) begin
        // [R02] Value stored as written
        if (st_reg.w_lane0) begin
          st_next.limit = st_reg.w_data[7:0];
        end
      end else if (addr_hit(st_reg.aw_addr, ADDR_SETUP)) begin
        if (st_reg.w_lane0) begin
          st_next.setup = st_reg.w_data[7:0];
        end
      end else if (addr_hit(st_reg.aw_addr, ADDR_STATUS)) begin
        // Write one to clear the sticky flags
        if (st_reg.w_lane0 && st_reg.w_data[ST_ACC_FLAG]) begin
          st_next.acc_flag = 1'b0;
        end
        if (st_reg.w_lane0 && st_reg.w_data[ST_FAST_FLAG]) begin
          st_next.fast_flag = 1'b0;
        end
      end else begin
        // Unmapped address
        st_next.bresp = RESP_SLVERR;
      end
    end

    // [R01] Accurate flag set
    if (acc_over) begin
      st_next.acc_flag = 1'b1;
    end
    // [R10] Fast flag after count
    if (fast_reached) begin
      st_next.fast_flag = 1'b1;
    end

    // Read channel: take address, answer next cycle
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      if (addr_hit(s_axi_araddr, ADDR_LIMIT)) begin
        st_next.rdata = {24'h0, st_reg.limit};
      end else if (addr_hit(s_axi_araddr, ADDR_SETUP)) begin
        st_next.rdata = {24'h0, st_reg.setup};
      end else if (addr_hit(s_axi_araddr, ADDR_STATUS)) begin
        st_next.rdata = status_word;
      end else begin
        st_next.rdata = 32'h0;
        st_next.rresp = RESP_SLVERR;
      end
    end

    // Ready outputs registered from the next holding state
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready = !st_next.w_have && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.limit <= LIMIT_RST;
      st_reg.setup <= SETUP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign pwm_out = st_reg.pwm;
  assign pwm_cut = st_reg.cut;
  assign accurate_flag = st_reg.acc_flag;
  assign fast_flag = st_reg.fast_flag;
  assign cc_mode_active = st_reg.cc_act;
  assign volt_second_balance_on = st_reg.setup[SET_VSB_ON];
  assign vs_sample_blank = st_reg.blank;
endmodule

//--- verilog/ocp_pkg.sv
// Shared constants of the overcurrent protection setup block.
// Assumes a 40 MHz controller clock and a 32-bit AXI4-Lite register bus.
package ocp_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_LIMIT = 8'h26;
  localparam logic [7:0] IDX_SETUP = 8'h27;
  localparam logic [7:0] IDX_STATUS = 8'h30;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_LIMIT = {2'h0, IDX_LIMIT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SETUP = {2'h0, IDX_SETUP, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] LIMIT_RST = 8'hFE;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam int SET_DEB_HI = 7;
  localparam int SET_DEB_LO = 6;
  localparam int SET_VSB_ON = 5;
  localparam int SET_BYPASS = 4;
  localparam int SET_CC_ON = 3;
  localparam int SET_BLANK = 2;
  localparam int SET_TMO_HI = 1;
  localparam int SET_TMO_LO = 0;
  localparam int ST_ACC_FLAG = 0;
  localparam int ST_FAST_FLAG = 1;
  localparam int ST_CC_ACT = 2;
  localparam int ST_CUT_ACT = 3;
  localparam int ST_READ_LO = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int DEB1_NS = 40;
  localparam int DEB2_NS = 80;
  localparam int DEB3_NS = 120;
  // Least times round up to whole cycles
  localparam int DEB1_CYC = (DEB1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB2_CYC = (DEB2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB3_CYC = (DEB3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Leading-edge blanking window, rounded down, at least one cycle
  localparam int BLANK_NS = 100;
  localparam int BLANK_CYC = (BLANK_NS / CLK_PERIOD_NS < 1) ? 1 : BLANK_NS / CLK_PERIOD_NS;
  // Consecutive switching cycles per timeout code
  localparam int TMO_CNT0 = 1;
  localparam int TMO_CNT1 = 2;
  localparam int TMO_CNT2 = 4;
  localparam int TMO_CNT3 = 8;
  // Constant-current level sits one tenth below the limit
  localparam int CC_MARGIN_DIV = 10;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- verilog/ocp_debounce.sv
// Debounce of the fast overcurrent level.
// Assumes the level input is already synchronised to aclk.
`timescale 1ns/100ps
module ocp_debounce (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Level and time select
  input wire logic level,
  input wire logic [1:0] code,
  // Trip output, combinational from state and level
  output logic trip
);
  import ocp_pkg::*;

  typedef struct packed {
    logic [2:0] run;
  } ocp_deb_s;

  ocp_deb_s st_reg;
  ocp_deb_s st_next;
  logic [2:0] need;

  // Cycles the level must already have stood high
  always_comb begin
    case (code)
      2'h0: need = 3'h0;
      2'h1: need = 3'(DEB1_CYC);
      2'h2: need = 3'(DEB2_CYC);
      default: need = 3'(DEB3_CYC);
    endcase
  end

  // Count consecutive high samples, saturating
  always_comb begin
    st_next = st_reg;
    if (!level) begin
      st_next.run = 3'h0;
    end else if (st_reg.run != 3'h7) begin
      st_next.run = st_reg.run + 3'h1;
    end
    trip = level && (st_reg.run >= need);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

//--- verilog/ocp_cycle_count.sv
// Counts consecutive switching cycles with a fast trip.
// Assumes cycle_start is a one-cycle pulse at each switching cycle start.
`timescale 1ns/100ps
module ocp_cycle_count (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events
  input wire logic cycle_start,
  input wire logic trip,
  input wire logic [1:0] code,
  // One-cycle pulse when the count is reached
  output logic reached
);
  import ocp_pkg::*;

  typedef struct packed {
    logic hit;
    logic [3:0] run;
    logic reached;
  } ocp_cnt_s;

  ocp_cnt_s st_reg;
  ocp_cnt_s st_next;
  logic [3:0] need;
  logic [3:0] run_inc;

  // Count per timeout code
  always_comb begin
    case (code)
      2'h0: need = 4'(TMO_CNT0);
      2'h1: need = 4'(TMO_CNT1);
      2'h2: need = 4'(TMO_CNT2);
      default: need = 4'(TMO_CNT3);
    endcase
  end

  // Close each cycle: extend or break the run
  always_comb begin
    st_next = st_reg;
    st_next.reached = 1'b0;
    run_inc = (st_reg.run == 4'hF) ? st_reg.run : st_reg.run + 4'h1;
    if (cycle_start) begin
      st_next.hit = 1'b0;
      if (st_reg.hit || trip) begin
        st_next.run = run_inc;
        st_next.reached = (run_inc == need);
      end else begin
        st_next.run = 4'h0;
      end
    end else if (trip) begin
      st_next.hit = 1'b1;
    end
    reached = st_reg.reached;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

//--- dv/ocp_assertions.sv
// Concurrent checks on the ports of the overcurrent protection block.
// Assumes the limit stays at or below 0xFE and switching cycles last over five clocks.
`timescale 1ns/100ps
module ocp_assertions #(
  parameter int PWM_N = 6
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Secondary reading and cycle pacing
  input wire logic [7:0] secondary_current_sense,
  input wire logic cycle_start,
  // PWM path
  input wire logic [PWM_N-1:0] pwm_in,
  input wire logic bridge_drive_second_mod,
  input wire logic bridge_drive_fourth_mod,
  input wire logic [PWM_N-1:0] pwm_out,
  input wire logic pwm_cut,
  // Flags and modes
  input wire logic accurate_flag,
  input wire logic fast_flag,
  input wire logic volt_second_balance_on,
  input wire logic vs_sample_blank
);
  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Full scale always exceeds a legal limit
  AST_ACC_OVER: assert property (secondary_current_sense == 8'hFF |=> accurate_flag)
    else $error("accurate flag missed a full-scale reading");
  AST_CUT_ZERO: assert property (pwm_cut |-> pwm_out == '0)
    else $error("pwm output on during cut");
  AST_CUT_HOLD: assert property (pwm_cut && !cycle_start |=> pwm_cut)
    else $error("cut ended inside a switching cycle");
  AST_CUT_END: assert property ($fell(pwm_cut) |-> $past(cycle_start))
    else $error("cut cleared away from a cycle start");
  AST_PASS: assert property (!pwm_cut && !volt_second_balance_on |=>
    pwm_cut || pwm_out == $past(pwm_in))
    else $error("pwm output does not follow input");
  AST_BALANCE: assert property (volt_second_balance_on && !pwm_cut |=> pwm_cut ||
    (pwm_out[1] == ($past(pwm_in[1]) | $past(bridge_drive_second_mod)) &&
    pwm_out[3] == ($past(pwm_in[3]) | $past(bridge_drive_fourth_mod))))
    else $error("balance modulation missing");
  AST_BLANK: assert property ($rose(vs_sample_blank) |-> $past(cycle_start) ##0
    vs_sample_blank [*4] ##1 !vs_sample_blank)
    else $error("blanking window wrong");
  AST_FAST: assert property ($rose(fast_flag) |-> $past(cycle_start, 2))
    else $error("fast flag set off the cycle boundary");
endmodule

bind ocp_top ocp_assertions #(.PWM_N(PWM_N)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .secondary_current_sense(secondary_current_sense),
  .cycle_start(cycle_start), .pwm_in(pwm_in), .bridge_drive_second_mod(bridge_drive_second_mod),
  .bridge_drive_fourth_mod(bridge_drive_fourth_mod), .pwm_out(pwm_out), .pwm_cut(pwm_cut),
  .accurate_flag(accurate_flag), .fast_flag(fast_flag),
  .volt_second_balance_on(volt_second_balance_on), .vs_sample_blank(vs_sample_blank)
);

//--- dv/testbench.sv
// Self-checking bench for ocp_top: AXI4-Lite register tasks and pin scenarios.
// Assumes the checker file is compiled beside the design.
`timescale 1ns/100ps
module testbench;
  import ocp_pkg::*;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, prim_over, ext_flag, cyc_start, mod2, mod4;
  logic cut, acc_flag, fast_flag, cc_on, vsb_on, blank;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] sec_read;
  logic [5:0] pwm_in, pwm_out;
  int n_fail, checks;
  // Limit under test and readings around its two thresholds
  localparam logic [7:0] LIM = 8'h80;
  logic [7:0] rdg [4] = '{8'h73, 8'h74, 8'h80, 8'h81};
  // Debounce cycles per code, cycle counts per timeout code
  int deb [4] = '{0, DEB1_CYC, DEB2_CYC, DEB3_CYC};
  int tmo [4] = '{1, 2, 4, 8};

  ocp_top #(.PWM_N(6)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .primary_current_sense_over(prim_over),
    .external_flag_input(ext_flag), .secondary_current_sense(sec_read),
    .cycle_start(cyc_start), .pwm_in(pwm_in), .bridge_drive_second_mod(mod2),
    .bridge_drive_fourth_mod(mod4), .pwm_out(pwm_out), .pwm_cut(cut),
    .accurate_flag(acc_flag), .fast_flag(fast_flag), .cc_mode_active(cc_on),
    .volt_second_balance_on(vsb_on), .vs_sample_blank(blank)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Prints counts and verdict, ends the run
  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Compares and counts
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // A wait that ran out
  task automatic hang;
    n_fail++;
    give_verdict();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write: both channels offered at once, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 40) hang();
    bready <= 1'b0;
    chk(bresp, er);
    @(posedge aclk);
  endtask
  // Read with expected data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 40) hang();
    rready <= 1'b0;
    chk(rdata, exp);
    chk(rresp, er);
    @(posedge aclk);
  endtask
  // One-cycle switching cycle start
  task automatic cyc;
    cyc_start <= 1'b1;
    @(posedge aclk);
    cyc_start <= 1'b0;
    @(posedge aclk);
  endtask
  // Overcurrent level on the sense or the flag pin for len cycles
  task automatic pulse(input logic ext, input int len);
    if (ext) ext_flag <= 1'b1;
    else prim_over <= 1'b1;
    tick(len);
    ext_flag <= 1'b0;
    prim_over <= 1'b0;
    tick(5);
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {prim_over, ext_flag, cyc_start, mod2, mod4} = '0;
    {awaddr, araddr, wdata, sec_read} = '0;
    pwm_in = 6'h3F;
    n_fail = 0;
    checks = 0;
    tick(2);
    aresetn <= 1'b1;
    tick(2);
    // Reset values, unmapped place refused
    rd(ADDR_LIMIT, 32'hFE, RESP_OKAY);
    rd(ADDR_SETUP, 32'h0, RESP_OKAY);
    rd(12'h010, 32'h0, RESP_SLVERR);
    wr(12'h010, 32'h55, RESP_SLVERR);
    wr(ADDR_LIMIT, {24'h0, LIM}, RESP_OKAY);
    wr(ADDR_SETUP, 32'h08, RESP_OKAY);
    rd(ADDR_LIMIT, {24'h0, LIM}, RESP_OKAY);
    rd(ADDR_SETUP, 32'h08, RESP_OKAY);
    // Readings around the constant-current level and the limit
    foreach (rdg[k]) begin
      sec_read <= rdg[k];
      tick(3);
      chk(cc_on, rdg[k] >= LIM - LIM / 10);
      chk(acc_flag, rdg[k] > LIM);
    end
    rd(ADDR_STATUS, 32'h8105, RESP_OKAY);
    wr(ADDR_SETUP, 32'h0, RESP_OKAY);
    tick(2);
    chk(cc_on, 1'b0);
    // Clear with the reading low, then a clear under full scale loses to the set
    sec_read <= 8'h0;
    wr(ADDR_STATUS, 32'h1, RESP_OKAY);
    tick(2);
    chk(acc_flag, 1'b0);
    sec_read <= 8'hFF;
    wr(ADDR_STATUS, 32'h1, RESP_OKAY);
    tick(2);
    chk(acc_flag, 1'b1);
    sec_read <= 8'h0;
    tick(2);
    // Debounce codes: short pulse ignored, long pulse cuts until next cycle
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_SETUP, {24'h0, c[1:0], 6'h0}, RESP_OKAY);
      if (c > 0) begin
        pulse(1'b0, deb[c]);
        chk(cut, 1'b0);
      end
      pulse(1'b0, deb[c] + 2);
      chk(cut, 1'b1);
      chk(pwm_out, 6'h0);
      cyc();
      tick(2);
      chk(cut, 1'b0);
      chk(pwm_out, pwm_in);
    end
    // Input source selection
    wr(ADDR_SETUP, 32'h10, RESP_OKAY);
    pulse(1'b0, 3);
    chk(cut, 1'b0);
    pulse(1'b1, 3);
    chk(cut, 1'b1);
    cyc();
    wr(ADDR_SETUP, 32'h0, RESP_OKAY);
    pulse(1'b1, 3);
    chk(cut, 1'b0);
    // Timeout codes: flag only after the full run of tripped cycles
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_SETUP, {30'h0, c[1:0]}, RESP_OKAY);
      cyc();
      wr(ADDR_STATUS, 32'h2, RESP_OKAY);
      for (int i = 1; i <= tmo[c]; i++) begin
        pulse(1'b0, 2);
        cyc();
        tick(2);
        chk(fast_flag, i == tmo[c]);
      end
    end
    // Balance modulation and blanking on, then off
    wr(ADDR_SETUP, 32'h24, RESP_OKAY);
    pwm_in <= 6'h0;
    mod2 <= 1'b1;
    mod4 <= 1'b1;
    cyc();
    chk(blank, 1'b1);
    chk(pwm_out, 6'h0A);
    chk(vsb_on, 1'b1);
    tick(5);
    chk(blank, 1'b0);
    wr(ADDR_SETUP, 32'h0, RESP_OKAY);
    cyc();
    chk(blank, 1'b0);
    chk(pwm_out, 6'h0);
    give_verdict();
  end
endmodule
